// File: src/psel_pkg.sv
// Package of register map, field layout and reset values for the secondary error log
package psel_pkg;
    localparam logic [11:0] OFS_HDR_LOG3 = 12'h124;
    localparam logic [11:0] OFS_HDR_LOG4 = 12'h128;
    localparam logic [11:0] OFS_FLT_STATUS = 12'h12C;
    localparam logic [11:0] OFS_FLT_MASK = 12'h130;
    localparam logic [11:0] OFS_FLT_SEVERITY = 12'h134;
    localparam logic [11:0] OFS_FLT_CONTROL = 12'h138;
    localparam logic [11:0] OFS_TXN_LOG0 = 12'h13C;
    localparam logic [11:0] OFS_TXN_LOG1 = 12'h140;
    localparam logic [11:0] OFS_TXN_LOG2 = 12'h144;
    localparam logic [11:0] OFS_TXN_LOG3 = 12'h148;
    localparam logic [11:0] OFS_RSVD_GAP = 12'h14C;
    localparam logic [11:0] OFS_CHAN_CAP_ID = 12'h150;
    // Interrupt registers sit above the error log map
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h180;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h184;

    localparam int FLT_BITS = 14;
    localparam logic [13:0] FLT_VALID = 14'h3FEF;
    localparam logic [13:0] MASK_RESET = 14'h17A8;
    localparam logic [13:0] SEV_RESET = 14'h1340;
    localparam logic [15:0] CHAN_CAP_ID = 16'h0002;
    localparam logic [4:0] FEP_RESET = 5'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Interrupt status bit positions
    localparam int IRQ_CORR = 0;
    localparam int IRQ_NONFATAL = 1;
    localparam int IRQ_FATAL = 2;
endpackage

// File: src/psel_cap_if.sv
// Interface carrying captured transaction fields between the log and the top
`timescale 1ns/1ps
interface psel_cap_if;
    logic load;
    logic [35:0] attr;
    logic [3:0] cmdLow;
    logic [3:0] cmdHigh;
    logic [31:0] addrLow;
    logic [31:0] addrHigh;
    logic [127:0] logWord;
    modport src (output load, output attr, output cmdLow, output cmdHigh,
        output addrLow, output addrHigh, input logWord);
    modport sink (input load, input attr, input cmdLow, input cmdHigh,
        input addrLow, input addrHigh, output logWord);
endinterface

// File: src/psel_txn_log.sv
// Secondary transaction header log storage
`timescale 1ns/1ps
module psel_txn_log
    import psel_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    psel_cap_if.sink cap
);
    typedef struct packed {
        logic [127:0] log;
    } psel_log_st_t;
    psel_log_st_t st_q;
    psel_log_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (cap.load) begin
            st_d.log[35:0] = cap.attr;
            st_d.log[39:36] = cap.cmdLow;
            st_d.log[43:40] = cap.cmdHigh;
            st_d.log[63:44] = 20'h00000;
            st_d.log[95:64] = cap.addrLow;
            st_d.log[127:96] = cap.addrHigh;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cap.logWord = st_q.log;

    property p_log_load;
        @(posedge clk) disable iff (rst)
        cap.load |=> st_q.log[95:64] == $past(cap.addrLow) && st_q.log[63:44] == 20'h00000;
    endproperty
    a_log_load: assert property (p_log_load) else $error("log not loaded");

    property p_log_hold;
        @(posedge clk) disable iff (rst)
        !cap.load |=> $stable(st_q.log);
    endproperty
    a_log_hold: assert property (p_log_hold) else $error("log changed without load");
endmodule

// File: src/psel_error_log.sv
// Top of the secondary error log register bank with Wishbone slave
//==============================================================
// Function
// - Two read-only header log words hold bytes 8 to 15, low byte at 31:24, zero at reset.
// - Status bits 0 to 3 and 5 to 13 are sticky write-one-to-clear and reset to zero; bit 4 reads zero.
// - Each error has a sticky read-write mask bit with the listed bits resetting to one.
// - Each error has a sticky read-write severity bit with the listed bits resetting to one.
// - A five-bit first-error pointer sits in bits 4:0 of the control word, upper bits zero.
// - Log bits 35:0 take byte enables and address/data of the attribute phase.
// - Log bits 39:36 take the command of the first address phase.
// - Log bits 43:40 take the second-phase command of a dual cycle, bits 63:44 read zero.
// - Log bits 95:64 take the first-phase address.
// - Log bits 127:96 take the dual-cycle upper address; all log fields sticky and read-only.
// - The first virtual channel word reads 0002h in bits 15:0.
// - The word between the log and the virtual channel word is reserved and reads zero.
//==============================================================
`timescale 1ns/1ps
module psel_error_log
    import psel_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] wbAdr,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    input wire logic wbWe,
    input wire logic [3:0] wbSel,
    input wire logic wbCyc,
    input wire logic wbStb,
    output logic wbAck,
    input wire logic [13:0] errEvent,
    input wire logic [35:0] txnAttr,
    input wire logic [3:0] txnCmdLow,
    input wire logic [3:0] txnCmdHigh,
    input wire logic [31:0] txnAddrLow,
    input wire logic [31:0] txnAddrHigh,
    input wire logic hdrLoad,
    input wire logic [63:0] hdrBytes,
    output logic reportFatal,
    output logic reportNonFatal,
    output logic irq
);
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic [31:0] hdr3;
        logic [31:0] hdr4;
        logic [13:0] status;
        logic [13:0] mask;
        logic [13:0] sev;
        logic [4:0] fep;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        logic fatal;
        logic nonFatal;
        logic irq;
    } psel_state_t;

    psel_state_t st_q;
    psel_state_t st_d;
    psel_cap_if cap();

    logic [13:0] evt;
    logic [13:0] wrMask;
    logic [31:0] wrData;
    logic [4:0] firstIdx;
    logic anyEvt;
    logic doWrite;
    logic doRead;

    psel_txn_log u_log (
        .clk(clk),
        .rst(rst),
        .cap(cap)
    );

    //==============================================================
    // Capture port toward the log
    assign evt = errEvent & FLT_VALID;
    assign anyEvt = |evt;
    assign cap.load = anyEvt && (st_q.status == 14'h0000);
    assign cap.attr = txnAttr;
    assign cap.cmdLow = txnCmdLow;
    assign cap.cmdHigh = txnCmdHigh;
    assign cap.addrLow = txnAddrLow;
    assign cap.addrHigh = txnAddrHigh;

    // Lowest pending index wins when several errors land together
    always_comb begin
        firstIdx = 5'h00;
        for (int i = FLT_BITS - 1; i >= 0; i--) begin
            if (evt[i]) begin
                firstIdx = 5'(i);
            end
        end
    end

    //==============================================================
    // Bus decode
    assign doWrite = wbCyc && wbStb && wbWe && !st_q.ack;
    assign doRead = wbCyc && wbStb && !wbWe && !st_q.ack;
    assign wrData = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}} & wbDatI;
    assign wrMask = wrData[13:0] & FLT_VALID;

    function automatic logic [13:0] psel_merge(input logic [13:0] old,
        input logic [31:0] din, input logic [3:0] sel);
        logic [13:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = din[7:0];
        end
        if (sel[1]) begin
            r[13:8] = din[13:8];
        end
        return r & FLT_VALID;
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.ack = wbCyc && wbStb && !st_q.ack;
        st_d.dat = 32'h00000000;
        if (hdrLoad) begin
            st_d.hdr3 = hdrBytes[63:32];
            st_d.hdr4 = hdrBytes[31:0];
        end
        if (doWrite) begin
            case (wbAdr)
                OFS_FLT_STATUS: st_d.status = st_q.status & ~wrMask;
                OFS_FLT_MASK: st_d.mask = psel_merge(st_q.mask, wbDatI, wbSel);
                OFS_FLT_SEVERITY: st_d.sev = psel_merge(st_q.sev, wbDatI, wbSel);
                OFS_IRQ_MASK: begin
                    if (wbSel[0]) begin
                        st_d.irqMask = wbDatI[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (doRead) begin
            case (wbAdr)
                OFS_HDR_LOG3: st_d.dat = st_q.hdr3;
                OFS_HDR_LOG4: st_d.dat = st_q.hdr4;
                OFS_FLT_STATUS: st_d.dat = {18'h00000, st_q.status};
                OFS_FLT_MASK: st_d.dat = {18'h00000, st_q.mask};
                OFS_FLT_SEVERITY: st_d.dat = {18'h00000, st_q.sev};
                OFS_FLT_CONTROL: st_d.dat = {27'h0000000, st_q.fep};
                OFS_TXN_LOG0: st_d.dat = cap.logWord[31:0];
                OFS_TXN_LOG1: st_d.dat = cap.logWord[63:32];
                OFS_TXN_LOG2: st_d.dat = cap.logWord[95:64];
                OFS_TXN_LOG3: st_d.dat = cap.logWord[127:96];
                OFS_RSVD_GAP: st_d.dat = 32'h00000000;
                OFS_CHAN_CAP_ID: st_d.dat = {16'h0000, CHAN_CAP_ID};
                OFS_IRQ_STATUS: begin
                    st_d.dat = {29'h00000000, st_q.irqStat};
                    st_d.irqStat = 3'h0;
                end
                OFS_IRQ_MASK: st_d.dat = {29'h00000000, st_q.irqMask};
                default: st_d.dat = 32'h00000000;
            endcase
        end
        // Set wins over a same-cycle clear
        st_d.status = st_d.status | evt;
        if (cap.load) begin
            st_d.fep = firstIdx;
        end
        st_d.fatal = |(evt & ~st_q.mask & st_q.sev);
        st_d.nonFatal = |(evt & ~st_q.mask & ~st_q.sev);
        if (st_d.fatal) begin
            st_d.irqStat[IRQ_FATAL] = 1'b1;
        end
        if (st_d.nonFatal) begin
            st_d.irqStat[IRQ_NONFATAL] = 1'b1;
        end
        if (anyEvt && !st_d.fatal && !st_d.nonFatal) begin
            st_d.irqStat[IRQ_CORR] = 1'b1;
        end
        st_d.irq = |(st_d.irqStat & st_q.irqMask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.mask <= MASK_RESET;
            st_q.sev <= SEV_RESET;
            st_q.fep <= FEP_RESET;
            st_q.irqStat <= IRQ_RESET;
            st_q.irqMask <= IRQ_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign wbDatO = st_q.dat;
    assign wbAck = st_q.ack;
    assign reportFatal = st_q.fatal;
    assign reportNonFatal = st_q.nonFatal;
    assign irq = st_q.irq;

    //==============================================================
    // Checks
    property p_ack_one;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbAck) |=> wbAck ##1 !wbAck;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not single cycle");

    property p_status_set;
        @(posedge clk) disable iff (rst)
        (errEvent[0]) |=> st_q.status[0];
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set");

    property p_rsvd_status;
        @(posedge clk) disable iff (rst)
        st_q.status[4] == 1'b0 && st_q.mask[4] == 1'b0;
    endproperty
    a_rsvd_status: assert property (p_rsvd_status) else $error("reserved bit set");

    property p_fep_first;
        @(posedge clk) disable iff (rst)
        (st_q.status == 14'h0000 && errEvent[13] && errEvent[12:0] == 13'h0000)
            |=> st_q.fep == 5'h0D;
    endproperty
    a_fep_first: assert property (p_fep_first) else $error("pointer wrong");

    property p_fep_keep;
        @(posedge clk) disable iff (rst)
        (st_q.status != 14'h0000) |=> $stable(st_q.fep);
    endproperty
    a_fep_keep: assert property (p_fep_keep) else $error("pointer moved");

    property p_masked_quiet;
        @(posedge clk) disable iff (rst)
        ((errEvent & FLT_VALID & ~st_q.mask) == 14'h0000) |=> !reportFatal && !reportNonFatal;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked error sent");

    property p_fatal_sev;
        @(posedge clk) disable iff (rst)
        (errEvent[12] && !st_q.mask[12] && st_q.sev[12]) |=> reportFatal;
    endproperty
    a_fatal_sev: assert property (p_fatal_sev) else $error("fatal not reported");

    property p_capid;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_CHAN_CAP_ID)
            |=> wbDatO == 32'h00000002;
    endproperty
    a_capid: assert property (p_capid) else $error("capability id wrong");

    property p_ctrl_upper;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_FLT_CONTROL)
            |=> wbDatO[31:5] == 27'h0000000;
    endproperty
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");

    property p_hdr_hold;
        @(posedge clk) disable iff (rst)
        !hdrLoad |=> $stable(st_q.hdr3) && $stable(st_q.hdr4);
    endproperty
    a_hdr_hold: assert property (p_hdr_hold) else $error("header log changed");

    property p_ack_data;
        @(posedge clk) disable iff (rst)
        !wbAck |-> wbDatO == 32'h00000000;
    endproperty
    a_ack_data: assert property (p_ack_data) else $error("read data outside ack");

    property p_status_clear;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && wbWe && !wbAck && wbAdr == OFS_FLT_STATUS && wbSel[0] && wbDatI[0]
            && !errEvent[0]) |=> !st_q.status[0];
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    property p_mask_write;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && wbWe && !wbAck && wbAdr == OFS_FLT_MASK && wbSel[1:0] == 2'b11)
            |=> {18'h00000, st_q.mask} == ($past(wbDatI) & {18'h00000, FLT_VALID});
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written");

    property p_sev_write;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && wbWe && !wbAck && wbAdr == OFS_FLT_SEVERITY && wbSel[1:0] == 2'b11)
            |=> {18'h00000, st_q.sev} == ($past(wbDatI) & {18'h00000, FLT_VALID});
    endproperty
    a_sev_write: assert property (p_sev_write) else $error("severity not written");

    property p_fep_range;
        @(posedge clk) disable iff (rst)
        st_q.fep <= 5'h0D && st_q.fep != 5'h04;
    endproperty
    a_fep_range: assert property (p_fep_range) else $error("pointer out of range");

    property p_nonfatal_sev;
        @(posedge clk) disable iff (rst)
        (errEvent[0] && !st_q.mask[0] && !st_q.sev[0]) |=> reportNonFatal;
    endproperty
    a_nonfatal_sev: assert property (p_nonfatal_sev) else $error("non-fatal not sent");

    property p_status_sticky;
        @(posedge clk) disable iff (rst)
        !(wbCyc && wbStb && wbWe && !wbAck && wbAdr == OFS_FLT_STATUS)
            |=> (st_q.status & $past(st_q.status)) == $past(st_q.status);
    endproperty
    a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

    property p_irq_clear;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_IRQ_STATUS
            && (errEvent & FLT_VALID) == 14'h0000) |=> st_q.irqStat == 3'h0 && !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq status not cleared");

    property p_irq_fatal;
        @(posedge clk) disable iff (rst)
        reportFatal |-> st_q.irqStat[IRQ_FATAL];
    endproperty
    a_irq_fatal: assert property (p_irq_fatal) else $error("fatal irq bit missing");

    property p_rsvd_read;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_RSVD_GAP)
            |=> wbDatO == 32'h00000000;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word not zero");

    property p_log_upper;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_TXN_LOG1)
            |=> wbDatO[31:12] == 20'h00000;
    endproperty
    a_log_upper: assert property (p_log_upper) else $error("log reserved bits set");

    property p_hdr_load;
        @(posedge clk) disable iff (rst)
        hdrLoad |=> {st_q.hdr3, st_q.hdr4} == $past(hdrBytes);
    endproperty
    a_hdr_load: assert property (p_hdr_load) else $error("header log not loaded");

    property p_status_read;
        @(posedge clk) disable iff (rst)
        (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == OFS_FLT_STATUS)
            |=> wbDatO[31:14] == 18'h00000;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status upper bits set");
endmodule

// File: testbench/psel_pcix_agent.sv
// Behavioural secondary bus agent that raises logged transaction errors
`timescale 1ns/1ps
module psel_pcix_agent (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] bitSel,
    input wire logic [7:0] tag,
    output logic [13:0] errEvent = 14'h0000,
    output logic [35:0] txnAttr = 36'h0,
    output logic [3:0] txnCmdLow = 4'h0,
    output logic [3:0] txnCmdHigh = 4'h0,
    output logic [31:0] txnAddrLow = 32'h0,
    output logic [31:0] txnAddrHigh = 32'h0
);
    // Fields flip every idle cycle so a capture in the wrong cycle shows
    always @(posedge clk) begin
        if (go) begin
            errEvent <= 14'h0001 << bitSel;
            txnAttr <= {4'hC, 24'hA11A00, tag};
            txnCmdLow <= 4'h7;
            txnCmdHigh <= 4'hD;
            txnAddrLow <= {24'h123456, tag};
            txnAddrHigh <= {24'h00ABCD, tag};
        end else begin
            errEvent <= 14'h0000;
            txnAttr <= ~txnAttr;
            txnCmdLow <= ~txnCmdLow;
            txnCmdHigh <= ~txnCmdHigh;
            txnAddrLow <= ~txnAddrLow;
            txnAddrHigh <= ~txnAddrHigh;
        end
    end
endmodule

// File: testbench/tb_psel_error_log.sv
// Self-checking bench for the secondary error log register bank
`timescale 1ns/1ps
module tb_psel_error_log;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] wbAdr = 12'h000;
    logic [31:0] wbDatI = 32'h0;
    logic [31:0] wbDatO;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'h0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbAck;
    logic [13:0] errEvent;
    logic [35:0] txnAttr;
    logic [3:0] txnCmdLow, txnCmdHigh;
    logic [31:0] txnAddrLow, txnAddrHigh;
    logic hdrLoad = 1'b0;
    logic [63:0] hdrBytes = 64'h0;
    logic reportFatal, reportNonFatal, irq;
    logic evGo = 1'b0;
    logic [3:0] evBit = 4'h0;
    logic [7:0] evTag = 8'h00;
    logic [31:0] q;
    int errorCnt = 0;
    int cmpCount = 0;
    int fatalN = 0;
    int nonFatalN = 0;
    int cycN = 0;
    logic [11:0] rstAdr [13] = '{12'h124, 12'h128, 12'h12C, 12'h130, 12'h134, 12'h138,
        12'h13C, 12'h140, 12'h144, 12'h148, 12'h14C, 12'h150, 12'h200};
    logic [31:0] rstVal [13] = '{32'h0, 32'h0, 32'h0, 32'h17A8, 32'h1340, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0002, 32'h0};

    psel_error_log i_dut (.clk(clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbWe(wbWe), .wbSel(wbSel), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbAck(wbAck), .errEvent(errEvent), .txnAttr(txnAttr), .txnCmdLow(txnCmdLow),
        .txnCmdHigh(txnCmdHigh), .txnAddrLow(txnAddrLow), .txnAddrHigh(txnAddrHigh),
        .hdrLoad(hdrLoad), .hdrBytes(hdrBytes), .reportFatal(reportFatal),
        .reportNonFatal(reportNonFatal), .irq(irq));
    psel_pcix_agent i_agent (.clk(clk), .go(evGo), .bitSel(evBit), .tag(evTag),
        .errEvent(errEvent), .txnAttr(txnAttr), .txnCmdLow(txnCmdLow),
        .txnCmdHigh(txnCmdHigh), .txnAddrLow(txnAddrLow), .txnAddrHigh(txnAddrHigh));

    initial begin
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    task wrapUp();
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycN++;
        if (reportFatal === 1'b1) fatalN++;
        if (reportNonFatal === 1'b1) nonFatalN++;
        if (cycN == 5000) begin
            errorCnt++;
            wrapUp();
        end
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmpCount++;
        if (s !== e) begin
            errorCnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask

    // Hold the request until ack is sampled high, then release
    task wb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        wbAdr <= a;
        wbWe <= w;
        wbDatI <= d;
        wbSel <= 4'hF;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(nm, q, e);
    endtask

    task fire(input logic [3:0] b, input logic [7:0] t);
        @(posedge clk);
        evGo <= 1'b1;
        evBit <= b;
        evTag <= t;
        @(posedge clk);
        evGo <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            wb(rstAdr[i], 1'b0, 32'h0);
            chk("reset", q, rstVal[i]);
        end
        @(posedge clk);
        hdrBytes <= 64'h0102030405060708;
        hdrLoad <= 1'b1;
        @(posedge clk);
        hdrLoad <= 1'b0;
        wb(12'h124, 1'b1, 32'hFFFFFFFF);
        rdChk("hdr3", 12'h124, 32'h01020304);
        rdChk("hdr4", 12'h128, 32'h05060708);
        // Data error is masked at reset: logged but not reported
        fire(4'd7, 8'h3C);
        rdChk("status", 12'h12C, 32'h80);
        rdChk("pointer", 12'h138, 32'h07);
        rdChk("attr", 12'h13C, 32'hA11A003C);
        rdChk("cmds", 12'h140, 32'h00000D7C);
        rdChk("addrLo", 12'h144, 32'h1234563C);
        rdChk("addrHi", 12'h148, 32'h00ABCD3C);
        chk("maskedRep", fatalN + nonFatalN, 0);
        fire(4'd0, 8'h55);
        rdChk("status2", 12'h12C, 32'h81);
        rdChk("ptrHeld", 12'h138, 32'h07);
        rdChk("logHeld", 12'h13C, 32'hA11A003C);
        chk("nonFatal", nonFatalN, 1);
        wb(12'h13C, 1'b1, 32'h0);
        rdChk("logRo", 12'h13C, 32'hA11A003C);
        wb(12'h12C, 1'b1, 32'h80);
        rdChk("w1c", 12'h12C, 32'h01);
        wb(12'h12C, 1'b1, 32'h01);
        rdChk("w1cAll", 12'h12C, 32'h0);
        wb(12'h134, 1'b1, 32'hFFFFFFFF);
        rdChk("sevRw", 12'h134, 32'h3FEF);
        wb(12'h130, 1'b1, 32'h0);
        rdChk("maskRw", 12'h130, 32'h0);
        fire(4'd12, 8'h99);
        chk("fatal", fatalN, 1);
        rdChk("ptrNew", 12'h138, 32'h0C);
        rdChk("attrNew", 12'h13C, 32'hA11A0099);
        rdChk("addrHiNew", 12'h148, 32'h00ABCD99);
        // Interrupt path: masked, unmasked, then cleared by reading
        chk("irqOff", {31'h0, irq}, 32'h0);
        wb(12'h184, 1'b1, 32'h7);
        repeat (3) @(posedge clk);
        chk("irqOn", {31'h0, irq}, 32'h1);
        rdChk("irqSt", 12'h180, 32'h7);
        repeat (3) @(posedge clk);
        chk("irqClr", {31'h0, irq}, 32'h0);
        rdChk("irqSt2", 12'h180, 32'h0);
        // Highest error index with a clean status must move the pointer to 13
        wb(12'h12C, 1'b1, 32'h1000);
        fire(4'd13, 8'h21);
        rdChk("ptr13", 12'h138, 32'h0D);
        rdChk("addrLo13", 12'h144, 32'h12345621);
        wrapUp();
    end
endmodule
